// ---- include/srsdr_pkg.sv ----
`default_nettype none
package srsdr_pkg;
   // register byte addresses (one aligned word each)
   localparam logic [7:0] STATUS_TWO_IDX  = 8'h05;
   localparam logic [7:0] DATA_HIGH_IDX   = 8'h06;
   localparam logic [7:0] DATA_LOW_IDX    = 8'h07;
   localparam logic [7:0] STATUS_ONE_ADDR = 8'h04;
   localparam logic [7:0] STATUS_TWO_ADDR = STATUS_TWO_IDX * 8'h04;
   localparam logic [7:0] DATA_HIGH_ADDR  = DATA_HIGH_IDX * 8'h04;
   localparam logic [7:0] DATA_LOW_ADDR   = DATA_LOW_IDX * 8'h04;
   localparam logic [7:0] CONTROL_ADDR    = 8'h20;
   localparam logic [7:0] TX_STATUS_ADDR  = 8'h24;

   // status_one bit positions
   localparam int RX_FULL_BIT  = 5;
   localparam int OVERRUN_BIT  = 3;
   localparam int NOISE_BIT    = 2;
   localparam int FRAMING_BIT  = 1;
   localparam int PARITY_BIT   = 0;
   // status_two bit positions
   localparam int LONG_BREAK_BIT = 2;
   localparam int PIN_DIR_BIT    = 1;
   localparam int RX_ACTIVE_BIT  = 0;
   // data_high bit positions
   localparam int RX_NINTH_BIT = 7;
   localparam int TX_NINTH_BIT = 6;
   // control bit positions
   localparam int NINE_BIT_POS   = 0;
   localparam int PAR_EN_POS     = 1;
   localparam int PAR_TYPE_POS   = 2;
   localparam int SINGLE_WIRE_POS = 3;

   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [3:0] OVERSAMPLE = 4'hf;
   localparam logic [3:0] SHORT_BREAK_BITS = 4'ha;
   localparam logic [3:0] LONG_BREAK_BITS  = 4'hd;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } srsdr_rx_state_t;

   typedef struct packed {
      logic       full;
      logic       overrun;
      logic       noise;
      logic       framing;
      logic       parity;
   } srsdr_flags_t;

   typedef struct packed {
      logic [8:0] data;
      logic       noise;
      logic       framing;
      logic       parity;
   } srsdr_frame_t;
endpackage
`default_nettype wire

// ---- logic/srsdr_top.sv ----
// Contract
// - noise flag sets together with receive-full, never on overrun.
// - noise flag clears by status_one read then data_low read.
// - framing flag sets on zero stop bit, with receive-full, not on overrun.
// - while framing flag set, no new data is accepted.
// - framing flag clears after status_one read showing it, then data_low read.
// - parity flag sets on parity mismatch when enabled, with receive-full.
// - parity flag clears by status_one read then data_low read.
// - only long-break and pin-direction bits of status_two are writable.
// - break length 10/11 bits when clear, 13/14 bits when set.
// - single-wire mode: direction bit 1 drives tx pin, 0 makes input.
// - receiver-active sets on low in first sample slot, clears on idle.
// - data reads give received character, writes load transmit buffer.
// - data_high bit 7 is received ninth bit, bit 6 transmit ninth.
// - transmit ninth bit persists until software rewrites it.
// - receive-full sets when a character moves into the data register.
// - overrun sets after second stop bit; frame discarded, old data kept.
// - character length bit selects 8 bits clear, 9 bits set.
`default_nettype none
module srsdr_top
   import srsdr_pkg::*;
#(
   parameter int DIV = 8
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        rxPin,
   output logic             txBufLoad,
   output logic      [8:0]  txBufData,
   output logic      [3:0]  breakBits,
   output logic             txPinOe
);
   if (DIV < 1 || DIV > 255) begin : g_div_check
      $error("DIV out of range");
   end

   logic [2:0]  rxSync_q;
   logic        rxLevel_q;
   logic        wrPend_q, rdPend_q;
   logic [7:0]  addr_q;
   logic [3:0]  ctrl_q;
   logic        longBreak_q, pinDir_q, rxActive_q;
   logic        txNinth_q;
   logic [8:0]  rxData_q;
   srsdr_flags_t flags_q;
   logic        armed_q;
   logic        s1ErrSeen_q;
   logic [7:0]  divCnt_q;
   logic        tick;
   srsdr_rx_state_t rxState_q;
   logic [3:0]  slot_q;
   logic [3:0]  bitIdx_q;
   logic [2:0]  smp_q;
   logic [8:0]  shift_q;
   logic        noiseAcc_q;
   logic [3:0]  idleCnt_q;
   logic        frameDone;
   srsdr_frame_t frame;
   logic        rdLow, rdS1;
   logic        majority;
   logic        parityCalc;
   logic [3:0]  dataBits;

   function automatic logic maj3(input logic [2:0] s);
      return (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
   endfunction

   // three-stage pin input, level moves when the last two agree
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxSync_q  <= 3'b111;
         rxLevel_q <= 1'b1;
      end else begin
         rxSync_q <= {rxSync_q[1:0], rxPin};
         if (rxSync_q[2] == rxSync_q[1]) begin
            rxLevel_q <= rxSync_q[2];
         end
      end
   end

   // ahb-lite slave, zero wait states
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wrPend_q <= 1'b0;
         rdPend_q <= 1'b0;
         addr_q   <= 8'h00;
      end else if (hready) begin
         wrPend_q <= hsel & htrans[1] & hwrite;
         rdPend_q <= hsel & htrans[1] & ~hwrite;
         addr_q   <= haddr[7:0];
      end
   end

   assign rdLow = rdPend_q && addr_q == DATA_LOW_ADDR;
   assign rdS1  = rdPend_q && addr_q == STATUS_ONE_ADDR;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // read data registered in address phase so hrdata stands from a flop
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         if (haddr[7:0] == STATUS_ONE_ADDR) begin
            hrdata <= {26'h000_0000, flags_q.full, 1'b0, flags_q.overrun,
                       flags_q.noise, flags_q.framing, flags_q.parity};
         end else if (haddr[7:0] == STATUS_TWO_ADDR) begin
            hrdata <= {29'h0000_0000, longBreak_q, pinDir_q, rxActive_q};
         end else if (haddr[7:0] == DATA_HIGH_ADDR) begin
            hrdata <= {24'h00_0000, rxData_q[8], txNinth_q, 6'h00};
         end else if (haddr[7:0] == DATA_LOW_ADDR) begin
            hrdata <= {24'h00_0000, rxData_q[7:0]};
         end else if (haddr[7:0] == CONTROL_ADDR) begin
            hrdata <= {28'h000_0000, ctrl_q};
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // register writes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q      <= 4'h0;
         longBreak_q <= 1'b0;
         pinDir_q    <= 1'b0;
         txNinth_q   <= 1'b0;
      end else if (wrPend_q) begin
         if (addr_q == STATUS_TWO_ADDR) begin
            longBreak_q <= hwdata[LONG_BREAK_BIT];
            pinDir_q    <= hwdata[PIN_DIR_BIT];
         end else if (addr_q == DATA_HIGH_ADDR) begin
            txNinth_q <= hwdata[TX_NINTH_BIT];
         end else if (addr_q == CONTROL_ADDR) begin
            ctrl_q <= hwdata[3:0];
         end
      end
   end

   // writing data_low loads the transmit buffer with the held ninth bit in nine-bit mode, ninth bit 0 otherwise
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         txBufLoad <= 1'b0;
         txBufData <= 9'h000;
      end else begin
         txBufLoad <= wrPend_q && addr_q == DATA_LOW_ADDR;
         if (wrPend_q && addr_q == DATA_LOW_ADDR) begin
            txBufData <= {txNinth_q & ctrl_q[NINE_BIT_POS], hwdata[7:0]};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         breakBits <= SHORT_BREAK_BITS;
         txPinOe   <= 1'b1;
      end else begin
         // the tx engine adds one bit for 9-bit frames, giving 11 or 14
         breakBits <= longBreak_q ? LONG_BREAK_BITS : SHORT_BREAK_BITS;
         txPinOe   <= ctrl_q[SINGLE_WIRE_POS] ? pinDir_q : 1'b1;
      end
   end

   // sample tick: 16 per bit time
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         divCnt_q <= 8'h00;
      end else if (divCnt_q == 8'(DIV - 1)) begin
         divCnt_q <= 8'h00;
      end else begin
         divCnt_q <= divCnt_q + 8'h01;
      end
   end
   assign tick = divCnt_q == 8'(DIV - 1);

   assign majority = maj3(smp_q);
   assign dataBits = ctrl_q[NINE_BIT_POS] ? 4'h9 : 4'h8;
   // parity bit included: xor of every received bit must equal the type bit
   assign parityCalc = ctrl_q[NINE_BIT_POS] ? ^shift_q : ^shift_q[8:1];

   // receive sequencer: samples at slots 7,8,9 of each bit
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxState_q  <= RX_IDLE;
         slot_q     <= 4'h0;
         bitIdx_q   <= 4'h0;
         smp_q      <= 3'b111;
         shift_q    <= 9'h000;
         noiseAcc_q <= 1'b0;
      end else if (tick) begin
         slot_q <= slot_q + 4'h1;
         if (slot_q >= 4'h7 && slot_q <= 4'h9) begin
            smp_q <= {smp_q[1:0], rxLevel_q};
         end
         case (rxState_q)
            RX_IDLE: begin
               noiseAcc_q <= 1'b0;
               // slot runs on while idle so that idle bit-times can be counted
               if (!rxLevel_q && !flags_q.framing) begin
                  rxState_q <= RX_START;
                  slot_q    <= 4'h1;
               end
            end
            RX_START: begin
               if (slot_q == OVERSAMPLE) begin
                  if (majority) begin
                     rxState_q <= RX_IDLE;
                  end else begin
                     rxState_q <= RX_DATA;
                     bitIdx_q  <= 4'h0;
                     noiseAcc_q <= smp_q != 3'b000;
                  end
               end
            end
            RX_DATA: begin
               if (slot_q == OVERSAMPLE) begin
                  shift_q    <= {majority, shift_q[8:1]};
                  noiseAcc_q <= noiseAcc_q | (smp_q != 3'b000 && smp_q != 3'b111);
                  bitIdx_q   <= bitIdx_q + 4'h1;
                  if (bitIdx_q == dataBits - 4'h1) begin
                     rxState_q <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (slot_q == OVERSAMPLE) begin
                  rxState_q <= RX_IDLE;
               end
            end
            default: rxState_q <= RX_IDLE;
         endcase
      end
   end

   assign frameDone = tick && rxState_q == RX_STOP && slot_q == OVERSAMPLE;
   always_comb begin
      frame.data    = ctrl_q[NINE_BIT_POS] ? shift_q : {1'b0, shift_q[8:1]};
      frame.noise   = noiseAcc_q | (smp_q != 3'b000 && smp_q != 3'b111);
      frame.framing = ~majority;
      frame.parity  = ctrl_q[PAR_EN_POS] && (parityCalc != ctrl_q[PAR_TYPE_POS]);
   end

   // receiver-active: low in first slot sets, one idle character clears
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxActive_q <= 1'b0;
         idleCnt_q  <= 4'h0;
      end else if (tick) begin
         if (rxState_q == RX_IDLE && !rxLevel_q) begin
            rxActive_q <= 1'b1;
            idleCnt_q  <= 4'h0;
         end else if (rxState_q == RX_IDLE && slot_q == OVERSAMPLE) begin
            if (idleCnt_q == dataBits + 4'h1) begin
               rxActive_q <= 1'b0;
            end else begin
               idleCnt_q <= idleCnt_q + 4'h1;
            end
         end
      end
   end

   // status_one read arms the clear; a set in the same cycle outranks it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         armed_q     <= 1'b0;
         s1ErrSeen_q <= 1'b0;
      end else if (rdS1) begin
         armed_q     <= 1'b1;
         s1ErrSeen_q <= flags_q.framing;
      end else if (rdLow) begin
         armed_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flags_q  <= '0;
         rxData_q <= DATA_RESET;
      end else if (frameDone && !flags_q.full) begin
         rxData_q        <= frame.data;
         flags_q.full    <= 1'b1;
         flags_q.noise   <= frame.noise;
         flags_q.framing <= frame.framing;
         flags_q.parity  <= frame.parity;
      end else if (frameDone) begin
         flags_q.overrun <= 1'b1;
         if (rdLow && armed_q) begin
            flags_q.full    <= 1'b0;
            flags_q.noise   <= 1'b0;
            flags_q.framing <= flags_q.framing & ~s1ErrSeen_q;
            flags_q.parity  <= 1'b0;
         end
      end else if (rdLow && armed_q) begin
         flags_q.full    <= 1'b0;
         flags_q.overrun <= 1'b0;
         flags_q.noise   <= 1'b0;
         flags_q.framing <= flags_q.framing & ~s1ErrSeen_q;
         flags_q.parity  <= 1'b0;
      end
   end

   a_noise_with_full: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(flags_q.noise) |-> $rose(flags_q.full))
      else $error("noise flag rose without receive-full");
   a_framing_with_full: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(flags_q.framing) |-> $rose(flags_q.full))
      else $error("framing flag rose without receive-full");
   a_framing_blocks_rx: assert property (@(posedge clk) disable iff (sys_rst)
      flags_q.framing && rxState_q == RX_IDLE |=> rxState_q == RX_IDLE)
      else $error("reception started with framing flag set");
   a_parity_gated: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(flags_q.parity) |-> $past(ctrl_q[PAR_EN_POS]) && $rose(flags_q.full))
      else $error("parity flag set while disabled");
   a_clear_needs_pair: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(flags_q.noise) |-> $past(rdLow) && $past(armed_q))
      else $error("noise flag cleared without the two-step access");
   a_overrun_keeps: assert property (@(posedge clk) disable iff (sys_rst)
      frameDone && flags_q.full |=> $stable(rxData_q) && flags_q.overrun)
      else $error("overrun frame disturbed data");
   a_s2_write_mask: assert property (@(posedge clk) disable iff (sys_rst)
      wrPend_q && addr_q == STATUS_TWO_ADDR |=> longBreak_q == $past(hwdata[LONG_BREAK_BIT])
      && pinDir_q == $past(hwdata[PIN_DIR_BIT]))
      else $error("status_two writable bits not stored");
   a_break_length: assert property (@(posedge clk) disable iff (sys_rst)
      ##1 breakBits == ($past(longBreak_q) ? LONG_BREAK_BITS : SHORT_BREAK_BITS))
      else $error("break length wrong");
   a_pin_direction: assert property (@(posedge clk) disable iff (sys_rst)
      ctrl_q[SINGLE_WIRE_POS] && !pinDir_q ##1 ctrl_q[SINGLE_WIRE_POS] && !pinDir_q
      |-> !txPinOe)
      else $error("tx pin driven as input");
   a_ninth_held: assert property (@(posedge clk) disable iff (sys_rst)
      !(wrPend_q && addr_q == DATA_HIGH_ADDR) |=> $stable(txNinth_q))
      else $error("transmit ninth bit changed without write");
endmodule
`default_nettype wire

// ---- test/srsdr_remote_tx.sv ----
`default_nettype none
module srsdr_remote_tx #(
   parameter int DIV = 4
) (
   input  wire logic clk,
   output logic      line
);
   timeunit 1ns;
   timeprecision 1ns;
   initial line = 1'b1;

   // one frame, lsb first; nz flips a single sample near the middle of the first data bit
   task automatic send(input logic [8:0] d, input int nb, input logic stp, input logic nz);
      logic b;
      int   i;
      int   k;
      for (i = 0; i < nb + 2; i++) begin
         b = (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : stp;
         for (k = 0; k < 16 * DIV; k++) begin
            line <= (nz && i == 1 && k >= 7 * DIV + DIV / 2 && k < 8 * DIV + DIV / 2) ? ~b : b;
            @(posedge clk);
         end
      end
      // released line rests high, as an idle line with pull-up would
      line <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ---- test/tb_serial_rx_status_and_data_regs.sv ----
`default_nettype none
module tb_serial_rx_status_and_data_regs
   import srsdr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DIV = 4;
   localparam int BIT = 16 * DIV;
   logic        clk = 1'b0;
   logic        sys_rst;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   wire logic   hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   wire logic   rxPin;
   logic        txBufLoad;
   logic [8:0]  txBufData;
   logic [3:0]  breakBits;
   logic        txPinOe;
   int          err_total = 0;
   int          num_checks = 0;
   int          loads = 0;

   always #25 clk = ~clk;
   assign hready = hreadyout;
   always @(posedge clk) if (txBufLoad === 1'b1) loads <= loads + 1;

   srsdr_top #(.DIV(DIV)) dut (
      .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxPin(rxPin),
      .txBufLoad(txBufLoad), .txBufData(txBufData), .breakBits(breakBits),
      .txPinOe(txPinOe));
   srsdr_remote_tx #(.DIV(DIV)) rmt (.clk(clk), .line(rxPin));

   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task chk(input logic [8:0] s, input logic [8:0] e);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, s, e);
      end
   endtask

   // waits for hready at a rising edge, never longer than the bound
   task wt;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1) begin
         err_total++;
         $display("mismatch at %0t: bus hang", $time);
         end_sim;
      end
   endtask

   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      wt;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wt;
      r = hrdata;
      chk({8'h00, hresp}, 9'h000);
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] v;
      ahb(1'b1, a, {24'h00_0000, d}, v);
   endtask

   task rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [31:0] v;
      ahb(1'b0, a, 32'h0000_0000, v);
      chk({1'b0, v[7:0] & m}, {1'b0, e});
   endtask

   task rx(input logic [8:0] d, input int nb, input logic stp, input logic nz);
      rmt.send(d, nb, stp, nz);
      repeat (8) @(posedge clk);
   endtask

   task tdone(input string s);
      $display("test %s done", s);
   endtask

   initial begin
      sys_rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      rc(DATA_LOW_ADDR, 8'hff, 8'h00);
      rc(DATA_HIGH_ADDR, 8'hff, 8'h00);
      rc(8'h40, 8'hff, 8'h00);
      chk({5'h00, breakBits}, {5'h00, SHORT_BREAK_BITS});
      tdone("reset");
      wr(STATUS_TWO_ADDR, 8'hff);
      rc(STATUS_TWO_ADDR, 8'hff, 8'h06);
      chk({5'h00, breakBits}, {5'h00, LONG_BREAK_BITS});
      wr(CONTROL_ADDR, 8'h08);
      repeat (3) @(posedge clk);
      chk({8'h00, txPinOe}, 9'h001);
      wr(STATUS_TWO_ADDR, 8'h00);
      repeat (3) @(posedge clk);
      chk({8'h00, txPinOe}, 9'h000);
      chk({5'h00, breakBits}, {5'h00, SHORT_BREAK_BITS});
      wr(CONTROL_ADDR, 8'h00);
      repeat (3) @(posedge clk);
      chk({8'h00, txPinOe}, 9'h001);
      tdone("status_two");
      // ninth bit first, then the low byte that launches the load
      wr(CONTROL_ADDR, 8'h01);
      wr(DATA_HIGH_ADDR, 8'hc0);
      wr(DATA_LOW_ADDR, 8'ha5);
      repeat (3) @(posedge clk);
      chk(loads[8:0], 9'h001);
      chk(txBufData, 9'h1a5);
      rc(DATA_HIGH_ADDR, 8'h80, 8'h00);
      wr(DATA_LOW_ADDR, 8'h3c);
      repeat (3) @(posedge clk);
      chk(txBufData, 9'h13c);
      wr(CONTROL_ADDR, 8'h00);
      wr(DATA_LOW_ADDR, 8'h77);
      repeat (3) @(posedge clk);
      chk({1'b0, txBufData[7:0]}, 9'h077);
      chk(loads[8:0], 9'h003);
      tdone("transmit");
      fork
         rx(9'h05a, 8, 1'b1, 1'b0);
         begin
            repeat (5 * BIT) @(posedge clk);
            rc(STATUS_TWO_ADDR, 8'h01, 8'h01);
         end
      join
      rc(STATUS_ONE_ADDR, 8'h2f, 8'h20);
      rc(DATA_LOW_ADDR, 8'hff, 8'h5a);
      rc(STATUS_ONE_ADDR, 8'h2f, 8'h00);
      repeat (12 * BIT) @(posedge clk);
      rc(STATUS_TWO_ADDR, 8'h01, 8'h00);
      tdone("receive");
      rx(9'h033, 8, 1'b1, 1'b1);
      rc(STATUS_ONE_ADDR, 8'h2f, 8'h24);
      rc(DATA_LOW_ADDR, 8'hff, 8'h33);
      rc(STATUS_ONE_ADDR, 8'h2f, 8'h00);
      // second frame is noisy but dropped, so noise must stay clear
      rx(9'h011, 8, 1'b1, 1'b0);
      rx(9'h022, 8, 1'b1, 1'b1);
      rc(STATUS_ONE_ADDR, 8'h2f, 8'h28);
      rc(DATA_LOW_ADDR, 8'hff, 8'h11);
      rc(STATUS_ONE_ADDR, 8'h2f, 8'h00);
      tdone("noise_overrun");
      wr(CONTROL_ADDR, 8'h02);
      rx(9'h001, 8, 1'b1, 1'b0);
      rc(STATUS_ONE_ADDR, 8'h2f, 8'h21);
      rc(DATA_LOW_ADDR, 8'hff, 8'h01);
      rx(9'h081, 8, 1'b1, 1'b0);
      rc(STATUS_ONE_ADDR, 8'h2f, 8'h20);
      rc(DATA_LOW_ADDR, 8'hff, 8'h81);
      wr(CONTROL_ADDR, 8'h06);
      rx(9'h081, 8, 1'b1, 1'b0);
      rc(STATUS_ONE_ADDR, 8'h2f, 8'h21);
      rc(DATA_LOW_ADDR, 8'hff, 8'h81);
      wr(CONTROL_ADDR, 8'h00);
      tdone("parity");
      // status read taken before the error, so the data read must not clear it
      rc(STATUS_ONE_ADDR, 8'h2f, 8'h00);
      rx(9'h044, 8, 1'b0, 1'b0);
      rc(DATA_LOW_ADDR, 8'hff, 8'h44);
      rc(STATUS_ONE_ADDR, 8'h2f, 8'h02);
      rx(9'h055, 8, 1'b1, 1'b0);
      rc(STATUS_ONE_ADDR, 8'h27, 8'h02);
      rc(DATA_LOW_ADDR, 8'hff, 8'h44);
      rc(STATUS_ONE_ADDR, 8'h27, 8'h00);
      rx(9'h066, 8, 1'b1, 1'b0);
      rc(STATUS_ONE_ADDR, 8'h27, 8'h20);
      rc(DATA_LOW_ADDR, 8'hff, 8'h66);
      tdone("framing");
      wr(CONTROL_ADDR, 8'h01);
      rx(9'h1c3, 9, 1'b1, 1'b0);
      rc(STATUS_ONE_ADDR, 8'h2f, 8'h20);
      rc(DATA_HIGH_ADDR, 8'h80, 8'h80);
      rc(DATA_LOW_ADDR, 8'hff, 8'hc3);
      // nine-bit frame with even parity selected and an odd count of ones
      wr(CONTROL_ADDR, 8'h03);
      rx(9'h100, 9, 1'b1, 1'b0);
      rc(STATUS_ONE_ADDR, 8'h2f, 8'h21);
      rc(DATA_HIGH_ADDR, 8'h80, 8'h80);
      rc(DATA_LOW_ADDR, 8'hff, 8'h00);
      rc(STATUS_ONE_ADDR, 8'h2f, 8'h00);
      tdone("nine_bit");
      end_sim;
   end
endmodule
`default_nettype wire
